// *** char_display_host_model.sv ***
/*
  Host processor model: strobes the parallel port; wait_ready polls busy when the caller asks for it.
  Assumes the port samples a request held four clocks on clk_i.
*/
`default_nettype none
module char_display_host_model (
  // Clock
  input wire logic clk_i,
  // Parallel bus
  output var char_display_pkg::host_bus_t host_o,
  input wire logic [7:0] host_data_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial host_o = '0;
  // Read cycles leave our data lines released, shown as the inverse of the last value
  task automatic xfer(input logic rs, input logic rw, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge clk_i);
    host_o.register_select <= rs;
    host_o.transfer_direction <= rw;
    host_o.data <= rw ? ~host_o.data : wd;
    host_o.enable <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd = host_data_i;
    host_o.enable <= 1'b0;
  endtask
  task automatic wait_ready(output logic ok, output logic [7:0] s);
    ok = 1'b0;
    for (int i = 0; i < 300 && !ok; i++) begin
      xfer(1'b0, 1'b1, 8'h00, s);
      ok = (s[7] === 1'b0);
    end
  endtask
endmodule // char_display_host_model
`default_nettype wire

// *** char_display_host_port.sv ***
/*
  Host parallel port of a character display controller with text and glyph RAM,
  display shift mapping and the master/slave cascade shift chain.
  Assumes host pins and cascade pins are synchronous to clk_i; the host holds
  enable high for at least three clocks on reads.
*/
`default_nettype none
module char_display_host_port (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Host parallel bus
  input wire char_display_pkg::host_bus_t host_i,
  output logic [7:0] host_data_o,
  output logic host_data_oe_n_o,
  // Display scan
  input wire logic [6:0] scan_pos_i,
  input wire logic scan_line_i,
  output logic [6:0] scan_addr_o,
  output logic [7:0] scan_char_o,
  input wire logic [5:0] glyph_addr_i,
  output logic [7:0] glyph_row_o,
  output logic display_on_o,
  // Cascade chain
  input wire logic master_select_i,
  input wire logic shift_direction_select_i,
  input wire logic [99:0] row_data_i,
  input wire logic row_load_i,
  input wire logic cascade_data_i,
  input wire logic cascade_shift_clock_i,
  input wire logic cascade_latch_i,
  output char_display_pkg::pin_drive_t cascade_data_o,
  output char_display_pkg::pin_drive_t cascade_shift_clock_o,
  output char_display_pkg::pin_drive_t cascade_latch_o,
  output logic [99:0] row_o
);
  // Pointer step, wrapping modulo 128 in both directions
  function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up);
    step_addr = up ? 7'(a + char_display_pkg::ADDR_ONE) : 7'(a - char_display_pkg::ADDR_ONE);
  endfunction

  // Display position to text RAM address
  function automatic logic [6:0] map_addr(input logic [6:0] pos, input logic line,
                                          input logic [6:0] ofs, input logic two);
    logic [5:0] low;
    low = 6'(pos[5:0] + ofs[5:0]);
    if (two) begin
      map_addr = {line, low};
    end else begin
      map_addr = 7'(pos + ofs);
    end
  endfunction

  char_display_pkg::host_state_t st_r;
  logic e_r;
  logic [7:0] busy_cnt_r;
  logic [6:0] address_pointer_r;
  logic glyph_sel_r;
  logic [7:0] data_holding_reg_r;
  logic [6:0] clr_cnt_r;
  logic inc_r;
  logic entry_shift_r;
  logic two_line_r;
  logic [6:0] offset_r;
  logic [7:0] text_rdata;
  logic [7:0] glyph_rdata;
  logic [6:0] text_addr;
  logic text_we;
  logic glyph_we;
  logic [7:0] text_wdata;
  logic busy_indicator;
  logic e_fall;
  logic e_rise;
  logic cmd_fire;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] cmd;

  assign busy_indicator = (st_r != char_display_pkg::ST_IDLE);
  assign e_rise = host_i.enable & ~e_r;
  assign e_fall = ~host_i.enable & e_r;
  assign cmd = host_i.data;
  // Every transfer except a status read is refused while busy
  assign cmd_fire = e_fall & ~busy_indicator & ~host_i.register_select & ~host_i.transfer_direction;
  assign wr_fire = e_fall & ~busy_indicator & host_i.register_select & ~host_i.transfer_direction;
  assign rd_fire = e_fall & ~busy_indicator & host_i.register_select & host_i.transfer_direction;

  assign text_addr = (st_r == char_display_pkg::ST_CLEAR) ? clr_cnt_r : address_pointer_r;
  assign text_we = (st_r == char_display_pkg::ST_CLEAR) | ((st_r == char_display_pkg::ST_ACCESS) & ~glyph_sel_r);
  assign glyph_we = (st_r == char_display_pkg::ST_ACCESS) & glyph_sel_r;
  assign text_wdata = (st_r == char_display_pkg::ST_CLEAR) ? char_display_pkg::FILL_CHAR : data_holding_reg_r;

  // Text RAM, 128 codes
  char_display_ram #(.AW(char_display_pkg::ADDR_W), .DW(char_display_pkg::DATA_W)) u_text_ram (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .a_addr_i(text_addr),
    .a_we_i(text_we),
    .a_wdata_i(text_wdata),
    .a_rdata_o(text_rdata),
    .b_addr_i(map_addr(scan_pos_i, scan_line_i, offset_r, two_line_r)),
    .b_rdata_o(scan_char_o)
  );

  // Glyph pattern RAM
  char_display_ram #(.AW(char_display_pkg::GLYPH_AW), .DW(char_display_pkg::DATA_W)) u_glyph_ram (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .a_addr_i(address_pointer_r[5:0]),
    .a_we_i(glyph_we),
    .a_wdata_i(data_holding_reg_r),
    .a_rdata_o(glyph_rdata),
    .b_addr_i(glyph_addr_i),
    .b_rdata_o(glyph_row_o)
  );

  // Host bus drive; the status byte never carries the instruction register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      e_r <= 1'b0;
      host_data_o <= char_display_pkg::DATA_ZERO;
      host_data_oe_n_o <= 1'b1;
    end else begin
      e_r <= host_i.enable;
      host_data_oe_n_o <= ~(host_i.enable & host_i.transfer_direction);
      if (host_i.register_select) begin
        host_data_o <= data_holding_reg_r;
      end else begin
        host_data_o <= {busy_indicator, address_pointer_r};
      end
    end
  end

  // Operation sequencer and busy timing
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= char_display_pkg::ST_IDLE;
      busy_cnt_r <= char_display_pkg::DATA_ZERO;
    end else begin
      case (st_r)
        char_display_pkg::ST_IDLE: begin
          busy_cnt_r <= char_display_pkg::BUSY_CYC;
          if (cmd_fire & cmd[char_display_pkg::CMD_CLEAR] & (cmd[7:1] == 7'h00)) begin
            st_r <= char_display_pkg::ST_CLEAR;
          end else if (cmd_fire | rd_fire) begin
            st_r <= char_display_pkg::ST_BUSY;
          end else if (wr_fire) begin
            st_r <= char_display_pkg::ST_ACCESS;
          end
        end
        char_display_pkg::ST_ACCESS: begin
          st_r <= char_display_pkg::ST_BUSY;
        end
        char_display_pkg::ST_CLEAR: begin
          if (clr_cnt_r == char_display_pkg::ADDR_LAST) begin
            st_r <= char_display_pkg::ST_BUSY;
          end
        end
        default: begin
          busy_cnt_r <= 8'(busy_cnt_r - 8'h01);
          if (busy_cnt_r == 8'h01) begin
            st_r <= char_display_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Clear walks every text RAM location
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      clr_cnt_r <= char_display_pkg::ADDR_ZERO;
    end else if (st_r == char_display_pkg::ST_CLEAR) begin
      clr_cnt_r <= 7'(clr_cnt_r + char_display_pkg::ADDR_ONE);
    end else begin
      clr_cnt_r <= char_display_pkg::ADDR_ZERO;
    end
  end

  // Data holding register, both directions
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_holding_reg_r <= char_display_pkg::DATA_ZERO;
    end else if (wr_fire) begin
      data_holding_reg_r <= host_i.data;
    end else if (e_rise & ~busy_indicator & host_i.register_select & host_i.transfer_direction) begin
      data_holding_reg_r <= glyph_sel_r ? glyph_rdata : text_rdata;
    end
  end

  // Address pointer and its RAM selection
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      address_pointer_r <= char_display_pkg::ADDR_ZERO;
      glyph_sel_r <= 1'b0;
    end else if (cmd_fire) begin
      if (cmd[char_display_pkg::CMD_SET_TEXT_ADDR]) begin
        address_pointer_r <= cmd[6:0];
        glyph_sel_r <= 1'b0;
      end else if (cmd[char_display_pkg::CMD_SET_GLYPH_ADDR]) begin
        address_pointer_r <= {1'b0, cmd[5:0]};
        glyph_sel_r <= 1'b1;
      end else if (cmd[char_display_pkg::CMD_FUNCTION]) begin
        address_pointer_r <= address_pointer_r;
      end else if (cmd[char_display_pkg::CMD_SHIFT]) begin
        if (~cmd[char_display_pkg::SH_DISPLAY]) begin
          address_pointer_r <= step_addr(address_pointer_r, ~cmd[char_display_pkg::SH_RIGHT]);
        end
      end else if (cmd[char_display_pkg::CMD_HOME] | cmd[char_display_pkg::CMD_CLEAR]) begin
        if (~cmd[char_display_pkg::CMD_DISPLAY] & ~cmd[char_display_pkg::CMD_ENTRY]) begin
          address_pointer_r <= char_display_pkg::ADDR_ZERO;
          glyph_sel_r <= 1'b0;
        end
      end
    end else if ((st_r == char_display_pkg::ST_ACCESS) | rd_fire) begin
      address_pointer_r <= step_addr(address_pointer_r, inc_r);
    end
  end

  // Mode bits and display shift offset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      inc_r <= 1'b1;
      entry_shift_r <= 1'b0;
      two_line_r <= 1'b0;
      display_on_o <= 1'b0;
      offset_r <= char_display_pkg::ADDR_ZERO;
    end else if (cmd_fire) begin
      if (cmd[7:6] != 2'b00) begin
        offset_r <= offset_r;
      end else if (cmd[char_display_pkg::CMD_FUNCTION]) begin
        two_line_r <= cmd[char_display_pkg::FN_TWO_LINE];
      end else if (cmd[char_display_pkg::CMD_SHIFT]) begin
        if (cmd[char_display_pkg::SH_DISPLAY]) begin
          offset_r <= step_addr(offset_r, ~cmd[char_display_pkg::SH_RIGHT]);
        end
      end else if (cmd[char_display_pkg::CMD_DISPLAY]) begin
        display_on_o <= cmd[char_display_pkg::DC_ON];
      end else if (cmd[char_display_pkg::CMD_ENTRY]) begin
        inc_r <= cmd[char_display_pkg::EN_INCREMENT];
        entry_shift_r <= cmd[char_display_pkg::EN_SHIFT];
      end else if (cmd[char_display_pkg::CMD_HOME]) begin
        offset_r <= char_display_pkg::ADDR_ZERO;
      end else if (cmd[char_display_pkg::CMD_CLEAR]) begin
        offset_r <= char_display_pkg::ADDR_ZERO;
        inc_r <= 1'b1;
      end
    end else if ((st_r == char_display_pkg::ST_ACCESS) & entry_shift_r & ~glyph_sel_r) begin
      offset_r <= step_addr(offset_r, inc_r);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      scan_addr_o <= char_display_pkg::ADDR_ZERO;
    end else begin
      scan_addr_o <= map_addr(scan_pos_i, scan_line_i, offset_r, two_line_r);
    end
  end

  // Cascade chain: the master clocks 100 stages out to the slave, then latches
  char_display_pkg::cascade_state_t cas_st_r;
  logic [99:0] chain_r;
  logic [3:0] half_cnt_r;
  logic [6:0] bit_cnt_r;
  logic cl_out_r;
  logic cl_in_r;
  logic lat_in_r;
  logic half_end;
  logic master_fall;
  logic slave_fall;
  logic slave_latch;

  assign half_end = (half_cnt_r == 4'h1);
  assign master_fall = (cas_st_r == char_display_pkg::CAS_SHIFT) & half_end & cl_out_r;
  assign slave_fall = ~master_select_i & cl_in_r & ~cascade_shift_clock_i;
  assign slave_latch = ~master_select_i & ~lat_in_r & cascade_latch_i;

  // Master sequencer; dropping master select aborts a frame so the pins go quiet
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cas_st_r <= char_display_pkg::CAS_IDLE;
      half_cnt_r <= char_display_pkg::CL_HALF_CYC;
      bit_cnt_r <= char_display_pkg::ADDR_ZERO;
      cl_out_r <= 1'b0;
    end else if (~master_select_i) begin
      cas_st_r <= char_display_pkg::CAS_IDLE;
      cl_out_r <= 1'b0;
    end else begin
      case (cas_st_r)
        char_display_pkg::CAS_IDLE: begin
          half_cnt_r <= char_display_pkg::CL_HALF_CYC;
          bit_cnt_r <= char_display_pkg::ADDR_ZERO;
          cl_out_r <= 1'b0;
          if (row_load_i) begin
            cas_st_r <= char_display_pkg::CAS_SHIFT;
          end
        end
        char_display_pkg::CAS_SHIFT: begin
          half_cnt_r <= half_end ? char_display_pkg::CL_HALF_CYC : 4'(half_cnt_r - 4'h1);
          if (half_end) begin
            cl_out_r <= ~cl_out_r;
          end
          if (master_fall) begin
            bit_cnt_r <= 7'(bit_cnt_r + char_display_pkg::ADDR_ONE);
            if (bit_cnt_r == char_display_pkg::STAGE_LAST) begin
              cas_st_r <= char_display_pkg::CAS_LATCH;
            end
          end
        end
        default: begin
          half_cnt_r <= half_end ? char_display_pkg::CL_HALF_CYC : 4'(half_cnt_r - 4'h1);
          if (half_end) begin
            cas_st_r <= char_display_pkg::CAS_IDLE;
          end
        end
      endcase
    end
  end

  // Shared chain: loaded and emptied as master, filled from the pin as slave
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      chain_r <= '0;
    end else if (master_select_i & row_load_i & (cas_st_r == char_display_pkg::CAS_IDLE)) begin
      chain_r <= row_data_i;
    end else if (master_fall) begin
      chain_r <= shift_direction_select_i ? {1'b0, chain_r[99:1]} : {chain_r[98:0], 1'b0};
    end else if (slave_fall) begin
      chain_r <= shift_direction_select_i ? {cascade_data_i, chain_r[99:1]} : {chain_r[98:0], cascade_data_i};
    end
  end

  // Pins; data changes on the rising clock so it stands still across the falling edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cl_in_r <= 1'b0;
      lat_in_r <= 1'b0;
      row_o <= '0;
      cascade_data_o <= 2'b01;
      cascade_shift_clock_o <= 2'b01;
      cascade_latch_o <= 2'b01;
    end else begin
      cl_in_r <= cascade_shift_clock_i;
      lat_in_r <= cascade_latch_i;
      if (slave_latch) begin
        row_o <= chain_r;
      end
      if ((cas_st_r == char_display_pkg::CAS_SHIFT) & half_end & ~cl_out_r) begin
        cascade_data_o.o <= shift_direction_select_i ? chain_r[0] : chain_r[99];
      end
      cascade_shift_clock_o.o <= cl_out_r;
      cascade_latch_o.o <= (cas_st_r == char_display_pkg::CAS_LATCH);
      cascade_data_o.oe_n <= ~master_select_i;
      cascade_shift_clock_o.oe_n <= ~master_select_i;
      cascade_latch_o.oe_n <= ~master_select_i;
    end
  end
endmodule // char_display_host_port
`default_nettype wire

// *** char_display_host_port_sva.sv ***
/*
  Concurrent checks on the host port, status answers and cascade pins.
  Assumes it is bound into char_display_host_port and sees only its ports.
*/
`default_nettype none
module char_display_host_port_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Host side
  input wire char_display_pkg::host_bus_t host_i,
  input wire logic [7:0] host_data_o,
  input wire logic host_data_oe_n_o,
  // Cascade side
  input wire logic master_select_i,
  input wire logic cascade_shift_clock_i,
  input wire logic cascade_latch_i,
  input wire logic row_load_i,
  input wire char_display_pkg::pin_drive_t cascade_data_o,
  input wire char_display_pkg::pin_drive_t cascade_shift_clock_o,
  input wire char_display_pkg::pin_drive_t cascade_latch_o,
  input wire logic [99:0] row_o
);
  logic [2:0] held_r;
  logic [7:0] since_wr_r;
  logic [2:0] quiet_r;
  logic stat;
  // Status is trusted only once the strobe has been held long enough to settle
  assign stat = (held_r >= 3'd3) && !host_i.register_select && host_i.transfer_direction;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) held_r <= 3'd0;
    else if (!host_i.enable) held_r <= 3'd0;
    else if (held_r != 3'd7) held_r <= held_r + 3'd1;
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) since_wr_r <= 8'hFF;
    else if (host_i.enable && (host_i.register_select || !host_i.transfer_direction)) since_wr_r <= 8'h00;
    else if (since_wr_r != 8'hFF) since_wr_r <= since_wr_r + 8'h01;
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) quiet_r <= 3'd0;
    else if (master_select_i || cascade_shift_clock_i || cascade_latch_i || row_load_i) quiet_r <= 3'd0;
    else if (quiet_r != 3'd4) quiet_r <= quiet_r + 3'd1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_IDLE_RELEASE: assert property (!host_i.enable [*3] |-> host_data_oe_n_o)
    else $error("data bus driven while host idle");
  AST_WRITE_RELEASE: assert property ((host_i.enable && !host_i.transfer_direction) [*3] |-> host_data_oe_n_o)
    else $error("data bus driven during a host write");
  AST_READ_DRIVE: assert property ((host_i.enable && host_i.transfer_direction) [*3] |-> !host_data_oe_n_o)
    else $error("data bus not driven during a host read");
  AST_BUSY_SET: assert property (stat && since_wr_r inside {[8:40]} |-> host_data_o[7])
    else $error("busy clear too soon after a transfer");
  AST_BUSY_CLEARS: assert property (stat && since_wr_r >= 8'd90 |-> !host_data_o[7])
    else $error("busy still set long after last transfer");
  AST_STATUS_STEADY: assert property (stat && $past(stat) && !host_data_o[7] |-> $stable(host_data_o[6:0]))
    else $error("pointer moved during a status read");
  AST_MASTER_DRIVES: assert property (master_select_i [*2] |-> !cascade_data_o.oe_n && !cascade_shift_clock_o.oe_n
    && !cascade_latch_o.oe_n)
    else $error("master not driving cascade pins");
  AST_SLAVE_RELEASES: assert property (!master_select_i [*2] |-> cascade_data_o.oe_n && cascade_shift_clock_o.oe_n
    && cascade_latch_o.oe_n)
    else $error("slave driving cascade pins");
  AST_ROW_QUIET: assert property (quiet_r == 3'd4 |-> $stable(row_o))
    else $error("row changed without a shift clock edge");
  COV_BUSY_SEEN: cover property (stat && host_data_o[7]);
  COV_MASTER: cover property (master_select_i && !cascade_data_o.oe_n);
  COV_SLAVE_QUIET: cover property (quiet_r == 3'd4);
endmodule // char_display_host_port_sva
bind char_display_host_port char_display_host_port_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .host_i(host_i),
  .host_data_o(host_data_o), .host_data_oe_n_o(host_data_oe_n_o), .master_select_i(master_select_i),
  .cascade_shift_clock_i(cascade_shift_clock_i), .cascade_latch_i(cascade_latch_i), .row_load_i(row_load_i),
  .cascade_data_o(cascade_data_o), .cascade_shift_clock_o(cascade_shift_clock_o),
  .cascade_latch_o(cascade_latch_o), .row_o(row_o));
`default_nettype wire

// *** char_display_host_port_tb_top.sv ***
/*
  Self-checking bench: RAM access, pointer stepping, busy, scan mapping, cascade shift.
  Assumes the host model and checker files are compiled alongside the design.
*/
`default_nettype none
module char_display_host_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, scan_line_i, display_on_o, master_select_i, shift_direction_select_i, row_load_i;
  logic cascade_data_i, cascade_shift_clock_i, cascade_latch_i, host_data_oe_n_o, ok, pc;
  char_display_pkg::host_bus_t host_bus;
  char_display_pkg::pin_drive_t cas_d, cas_c, cas_l;
  logic [7:0] host_data_o, scan_char_o, glyph_row_o, s, b, r;
  logic [7:0] d [8];
  logic [6:0] scan_pos_i, scan_addr_o;
  logic [5:0] glyph_addr_i, g;
  logic [99:0] row_data_i, row_o;
  int seed, num_errors, compares, cycles, falls;
  char_display_host_port u_dut (.clk_i(clk_i), .rst_i(rst_i), .host_i(host_bus), .host_data_o(host_data_o),
    .host_data_oe_n_o(host_data_oe_n_o), .scan_pos_i(scan_pos_i), .scan_line_i(scan_line_i),
    .scan_addr_o(scan_addr_o), .scan_char_o(scan_char_o), .glyph_addr_i(glyph_addr_i), .glyph_row_o(glyph_row_o),
    .display_on_o(display_on_o), .master_select_i(master_select_i),
    .shift_direction_select_i(shift_direction_select_i), .row_data_i(row_data_i), .row_load_i(row_load_i),
    .cascade_data_i(cascade_data_i), .cascade_shift_clock_i(cascade_shift_clock_i),
    .cascade_latch_i(cascade_latch_i), .cascade_data_o(cas_d), .cascade_shift_clock_o(cas_c),
    .cascade_latch_o(cas_l), .row_o(row_o));
  char_display_host_model u_host (.clk_i(clk_i), .host_o(host_bus), .host_data_i(host_data_o));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic wrap_up();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic chk_row(input logic [99:0] got, input logic [99:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t row mismatch got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic ready(output logic [7:0] st);
    u_host.wait_ready(ok, st);
    if (!ok) chk8(8'hFF, 8'h00, "busy never cleared");
  endtask
  task automatic cmd(input logic [7:0] c);
    ready(s);
    u_host.xfer(1'b0, 1'b0, c, s);
  endtask
  task automatic wr_data(input logic [7:0] v);
    ready(s);
    u_host.xfer(1'b1, 1'b0, v, s);
  endtask
  task automatic rd_data(output logic [7:0] v);
    ready(s);
    u_host.xfer(1'b1, 1'b1, 8'h00, v);
  endtask
  task automatic scan_at(input logic line, input logic [6:0] pos, input logic [6:0] exp);
    scan_line_i <= line;
    scan_pos_i <= pos;
    repeat (4) @(posedge clk_i);
    chk8({1'b0, scan_addr_o}, {1'b0, exp}, "scan address");
  endtask
  task automatic shift_row(input logic dir);
    logic [99:0] exp;
    logic bit_v;
    shift_direction_select_i <= dir;
    for (int k = 0; k < 100; k++) begin
      bit_v = 1'($random(seed));
      exp[dir ? k : 99 - k] = bit_v;
      cascade_data_i <= bit_v;
      cascade_shift_clock_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      cascade_shift_clock_i <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    cascade_latch_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    cascade_latch_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk_row(row_o, exp);
  endtask
  initial begin
    seed = 32'h297A;
    rst_i = 1'b1;
    {scan_line_i, master_select_i, shift_direction_select_i, row_load_i} = 4'h0;
    {cascade_data_i, cascade_shift_clock_i, cascade_latch_i} = 3'h0;
    scan_pos_i = 7'h00;
    glyph_addr_i = 6'h00;
    row_data_i = '0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    u_host.xfer(1'b0, 1'b1, 8'h00, s);
    chk8(8'(s[7]), 8'h00, "busy after reset");
    $display("test reset done");
    cmd(8'h20);
    cmd(8'h06);
    cmd(8'hFC);
    u_host.xfer(1'b0, 1'b1, 8'h00, s);
    chk8(8'(s[7]), 8'h01, "busy after command");
    // Start near the top so the pointer has to wrap
    for (int k = 0; k < 8; k++) begin
      d[k] = 8'($random(seed));
      wr_data(d[k]);
    end
    ready(s);
    chk8(s, 8'h04, "pointer after writes");
    cmd(8'hFC);
    ready(s);
    chk8(s, 8'h7C, "pointer after address set");
    for (int k = 0; k < 8; k++) begin
      rd_data(b);
      chk8(b, d[k], "text read back");
    end
    ready(s);
    chk8(s, 8'h04, "pointer after reads");
    cmd(8'h04);
    cmd(8'h80);
    wr_data(8'hA5);
    ready(s);
    chk8(s, 8'h7F, "pointer after decrement");
    $display("test text ram done");
    g = 6'($random(seed));
    glyph_addr_i <= g;
    cmd(8'h40 | {2'b00, g});
    ready(s);
    chk8(s, {2'b00, g}, "glyph pointer");
    b = 8'($random(seed));
    cmd(8'h06);
    wr_data(b);
    cmd(8'h40 | {2'b00, g});
    rd_data(r);
    chk8(r, b, "glyph read back");
    chk8(glyph_row_o, b, "glyph row port");
    cmd(8'h0C);
    ready(s);
    chk8(8'(display_on_o), 8'h01, "display on");
    $display("test glyph ram done");
    cmd(8'h28);
    ready(s);
    scan_at(1'b1, 7'h05, 7'h45);
    cmd(8'h1C);
    ready(s);
    scan_at(1'b0, 7'h00, 7'h3F);
    scan_at(1'b1, 7'h00, 7'h7F);
    cmd(8'h20);
    ready(s);
    scan_at(1'b0, 7'h7D, 7'h7C);
    chk8(scan_char_o, d[0], "scan character");
    $display("test scan done");
    master_select_i <= 1'b1;
    row_data_i <= 100'({$random(seed), $random(seed), $random(seed), $random(seed)});
    row_load_i <= 1'b1;
    @(posedge clk_i);
    row_load_i <= 1'b0;
    falls = 0;
    pc = 1'b0;
    repeat (1200) begin
      @(posedge clk_i);
      #1;
      if (pc & ~cas_c.o) falls++;
      pc = cas_c.o;
    end
    chk8(8'(falls), 8'd100, "master clock falling edges");
    chk8({5'h00, cas_d.oe_n, cas_c.oe_n, cas_l.oe_n}, 8'h00, "master pin enables");
    master_select_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk8({5'h00, cas_d.oe_n, cas_c.oe_n, cas_l.oe_n}, 8'h07, "slave pin enables");
    shift_row(1'b0);
    shift_row(1'b1);
    $display("test cascade done");
    wrap_up();
  end
endmodule // char_display_host_port_tb_top
`default_nettype wire

// *** char_display_pkg.sv ***
/*
  Shared constants, types and state encodings for the character display host port.
  Assumes a single 100 MHz clock and an asynchronous active-high reset in every user but the host model, which has no reset.
*/
`default_nettype none
package char_display_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int BUSY_NS = 600;
  localparam int BUSY_CYCLES = (BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] BUSY_CYC = 8'(BUSY_CYCLES);
  localparam int CL_HALF_NS = 50;
  localparam int CL_HALF_CYCLES = (CL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] CL_HALF_CYC = 4'(CL_HALF_CYCLES);

  // Widths and sizes
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int GLYPH_AW = 6;
  localparam int LINE_AW = 6;
  localparam int SHIFT_STAGES = 100;
  localparam logic [6:0] ADDR_ZERO = 7'h00;
  localparam logic [6:0] ADDR_ONE = 7'h01;
  localparam logic [6:0] ADDR_LAST = 7'h7F;
  localparam logic [6:0] STAGE_LAST = 7'(SHIFT_STAGES - 1);
  localparam logic [7:0] DATA_ZERO = 8'h00;
  localparam logic [7:0] FILL_CHAR = 8'h20;

  // Instruction byte: position of the leading one selects the command
  localparam int CMD_SET_TEXT_ADDR = 7;
  localparam int CMD_SET_GLYPH_ADDR = 6;
  localparam int CMD_FUNCTION = 5;
  localparam int CMD_SHIFT = 4;
  localparam int CMD_DISPLAY = 3;
  localparam int CMD_ENTRY = 2;
  localparam int CMD_HOME = 1;
  localparam int CMD_CLEAR = 0;
  // Argument bits inside the commands
  localparam int FN_TWO_LINE = 3;
  localparam int SH_DISPLAY = 3;
  localparam int SH_RIGHT = 2;
  localparam int DC_ON = 2;
  localparam int EN_INCREMENT = 1;
  localparam int EN_SHIFT = 0;
  // Status byte
  localparam int BUSY_BIT = 7;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCESS = 2'b01,
    ST_BUSY = 2'b11,
    ST_CLEAR = 2'b10
  } host_state_t;

  typedef enum logic [1:0] {
    CAS_IDLE = 2'b00,
    CAS_SHIFT = 2'b01,
    CAS_LATCH = 2'b11
  } cascade_state_t;

  typedef struct packed {
    logic register_select;
    logic transfer_direction;
    logic enable;
    logic [7:0] data;
  } host_bus_t;

  typedef struct packed {
    logic o;
    logic oe_n;
  } pin_drive_t;
endpackage : char_display_pkg
`default_nettype wire

// *** char_display_ram.sv ***
/*
  Two-port RAM: port A reads and writes, port B reads only; both read ports registered.
  Assumes one clock; no reset on the array, read registers clear on reset.
*/
`default_nettype none
module char_display_ram #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Port A
  input wire logic [AW-1:0] a_addr_i,
  input wire logic a_we_i,
  input wire logic [DW-1:0] a_wdata_i,
  output logic [DW-1:0] a_rdata_o,
  // Port B
  input wire logic [AW-1:0] b_addr_i,
  output logic [DW-1:0] b_rdata_o
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_i) begin
    if (a_we_i) begin
      mem[a_addr_i] <= a_wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      a_rdata_o <= '0;
      b_rdata_o <= '0;
    end else begin
      a_rdata_o <= mem[a_addr_i];
      b_rdata_o <= mem[b_addr_i];
    end
  end
endmodule // char_display_ram
`default_nettype wire
